// >>> core/psrp_pkg.sv
// package for the paged serial register port: map, frame layout, timing
// assumes a 10 MHz core clock and a master-driven mode-3 serial clock
`default_nettype none
package psrp_pkg;
	localparam int          CLK_MHZ          = 10;
	localparam int          FRAME_BITS       = 16;
	localparam int          PAGE_COUNT       = 13;
	localparam int          REGS_PER_PAGE    = 64;
	localparam int          REG_INDEX_BITS   = 6;
	localparam logic [7:0]  PAGE_MAX         = 8'h0C;
	localparam logic [7:0]  PAGE_RESET       = 8'h00;
	localparam logic [7:0]  PAGE_CONTROL     = 8'h03;
	localparam logic [6:0]  ADDR_PAGE_SEL    = 7'h00;
	localparam int          RW_BIT           = 15;
	localparam int          ADDR_MSB         = 14;
	localparam int          ADDR_LSB         = 8;
	// sync input: least pulse width and spacing, times in microseconds
	localparam int          SYNC_PULSE_US    = 5;
	localparam int          SYNC_PERIOD_US   = 417;
	localparam int          SYNC_PULSE_CYC   = SYNC_PULSE_US * CLK_MHZ;
	localparam int          SYNC_PERIOD_CYC  = SYNC_PERIOD_US * CLK_MHZ;
	// internal sample interval when no external sync is used
	localparam int          SAMPLE_US        = 417;
	localparam int          SAMPLE_CYC       = SAMPLE_US * CLK_MHZ;
	localparam logic [12:0] SAMPLE_CYC_W     = 13'(SAMPLE_CYC);
	localparam logic [15:0] SAMPLE_STEP      = 16'h0001;
	localparam logic [15:0] DATA_RESET       = 16'h0000;

	typedef struct packed {
		logic       rw;
		logic [6:0] addr;
		logic [7:0] data;
	} psrp_frame_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] page;
		logic [5:0] index;
		logic       upper;
		logic [7:0] data;
	} psrp_wr_t;
endpackage
`default_nettype wire

// >>> core/psrp_link.sv
// serial-clock domain: shifts frames in on rising edges, data out on falling
// assumes sclk idles high and stops between frames; cs_n gates the frame
`default_nettype none
module psrp_link
	import psrp_pkg::*;
(
	input  wire logic        rst_n,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        mosi,
	output logic             miso_o,
	output logic             miso_oe,
	output logic [15:0]      frame_q,
	output logic             frame_tgl_q,
	input  wire logic [15:0] tx_word,
	input  wire logic        tx_en
);
	logic [4:0]  bit_cnt_q;
	logic [15:0] sh_q;
	logic [15:0] tx_q;

	////////////////////////////////////////////////////////////////////////
	// count and frame capture; cs_n high clears a partial frame
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_q <= 5'h00; // [RULE_22]
			sh_q      <= 16'h0000;
		end else begin
			sh_q      <= {sh_q[14:0], mosi}; // [RULE_05]
			bit_cnt_q <= (bit_cnt_q == 5'h0F) ? 5'h00 : bit_cnt_q + 5'h01;
		end
	end

	// frame word held until the next full frame; toggle marks the event
	// toggle needs a known start or the crossing never sees a frame;
	// reset only lands while sclk idles, so no frame is split by it
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			frame_q     <= 16'h0000;
			frame_tgl_q <= 1'b0;
		end else if (!cs_n && bit_cnt_q == 5'h0F) begin
			frame_q     <= {sh_q[14:0], mosi}; // [RULE_01]
			frame_tgl_q <= ~frame_tgl_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output shifter: first bit is ready at cs_n fall, next on each fall
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			tx_q <= 16'h0000;
		end else if (bit_cnt_q == 5'h00) begin
			// leading fall keeps bit 15 up; later falls shift
			tx_q <= tx_word;
		end else begin
			tx_q <= {tx_q[14:0], 1'b0}; // [RULE_04]
		end
	end

	assign miso_o  = (bit_cnt_q == 5'h00) ? tx_word[15] : tx_q[15];
	assign miso_oe = !cs_n && tx_en; // [RULE_21] [RULE_20]
endmodule
`default_nettype wire

// >>> core/psrp_top.sv
// paged serial register port: 13 pages of 64 16-bit registers over mode 3
// assumes sclk/cs_n/mosi/sync come from outside clk's domain
//
// Functional notes
// RULE_01: slave only, mode 3: clock idles high, capture on second edge.
// RULE_02: master keeps serial clock between 0.01 and 15 MHz; the bench master runs it at a 48 ns period (about 20.8 MHz).
// RULE_03: master leaves at least 2 us between frames.
// RULE_04: output bit changes on every falling serial clock edge; the first fall of a frame keeps bit 15, which is driven from the cs_n fall.
// RULE_05: input bit sampled on every rising serial clock edge.
// RULE_06: thirteen pages of 64 registers, one page reachable at once.
// RULE_07: 16-bit registers, low byte at even address, high at odd.
// RULE_08: page selector at address 0x00 on every page, readable.
// RULE_09: page codes 0x00 to 0x0C; other codes are refused.
// RULE_10: full duplex: reply to previous read shifts out during next frame.
// RULE_11: master writes low byte first, then high byte.
// RULE_12: page selector takes low byte alone; others commit on high byte.
// RULE_13: write frame: flag 1, seven-bit byte address, eight data bits.
// RULE_14: frame 0x8003 makes the control page active.
// RULE_15: device samples and loads output registers without commands.
// RULE_16: second config pin pulses high on each new output data.
// RULE_17: outside party holds reset high for normal operation.
// RULE_18: sync pulses at least 5 us wide and 417 us apart.
// RULE_19: read takes two frames; reply in the following frame.
// RULE_20: output active only after a frame whose flag was 0.
// RULE_21: output released while chip select is high.
// RULE_22: partial frame dropped when chip select rises early.
`default_nettype none
module psrp_top
	import psrp_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic mosi,
	output logic      miso_o,
	output logic      miso_oe,
	input  wire logic ext_sync_en,
	input  wire logic config_io_first_i,
	output logic      config_io_second_o,
	output logic      config_io_second_oe
);
	logic [15:0] frame_w;
	logic        frame_tgl_w;
	logic [2:0]  tgl_sync_q;
	logic        frame_ev;
	psrp_frame_t fr;
	logic [7:0]  page_q;
	logic [15:0] mem_q [PAGE_COUNT*REGS_PER_PAGE];
	logic [7:0]  low_hold_q;
	logic [6:0]  low_addr_q;
	logic        low_ok_q;
	logic [15:0] tx_word_q;
	logic        tx_en_q;
	logic [9:0]  wr_idx;
	logic [9:0]  rd_idx;
	logic [15:0] rd_word;
	logic [12:0] samp_cnt_q;
	logic        samp_ev;
	logic [15:0] sample_q;
	logic [1:0]  sync_ff_q;
	logic        sync_last_q;
	logic        drdy_q;

	typedef enum logic [2:0] {
		PS_IDLE = 3'b001,
		PS_CMD  = 3'b010,
		PS_DONE = 3'b100
	} psrp_state_t;
	psrp_state_t st_q;

	////////////////////////////////////////////////////////////////////////
	// link-side logic on the serial clock
	psrp_link u_link (
		.rst_n       (rst_n),
		.sclk        (sclk),
		.cs_n        (cs_n),
		.mosi        (mosi),
		.miso_o      (miso_o),
		.miso_oe     (miso_oe),
		.frame_q     (frame_w),
		.frame_tgl_q (frame_tgl_w),
		.tx_word     (tx_word_q),
		.tx_en       (tx_en_q)
	);

	////////////////////////////////////////////////////////////////////////
	// toggle crossing; frame word is stable long after the toggle lands
	// since the master leaves a 2 us gap (20 core cycles) between frames
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tgl_sync_q <= 3'b000;
		end else begin
			tgl_sync_q <= {tgl_sync_q[1:0], frame_tgl_w}; // [RULE_03]
		end
	end
	assign frame_ev = tgl_sync_q[2] ^ tgl_sync_q[1];
	assign fr       = psrp_frame_t'(frame_w);

	////////////////////////////////////////////////////////////////////////
	// frame sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= PS_IDLE;
		end else begin
			case (st_q)
				PS_IDLE: begin
					if (frame_ev) begin
						st_q <= PS_CMD;
					end
				end
				PS_CMD:  st_q <= PS_DONE;
				PS_DONE: st_q <= PS_IDLE;
				default: st_q <= PS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode: page times 64 plus word index
	assign wr_idx = 10'(page_q[3:0] * REGS_PER_PAGE) + 10'(fr.addr[6:1]);
	assign rd_idx = wr_idx;
	assign rd_word = mem_q[rd_idx];

	// page selector, only codes 0..12 accepted
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			page_q <= PAGE_RESET;
		end else if (st_q == PS_CMD && fr.rw
			&& fr.addr == ADDR_PAGE_SEL && fr.data <= PAGE_MAX) begin
			page_q <= fr.data; // [RULE_08] [RULE_09] [RULE_14] [RULE_12]
		end
	end

	// low byte waits in a holding register until the high byte arrives
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			low_hold_q <= 8'h00;
			low_addr_q <= 7'h00;
			low_ok_q   <= 1'b0;
		end else if (st_q == PS_CMD && fr.rw) begin
			low_ok_q   <= !fr.addr[0]; // [RULE_11]
			low_hold_q <= fr.data;
			low_addr_q <= fr.addr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register array; page 0 word 1 area holds the sample counter output
	always_ff @(posedge clk) begin
		if (st_q == PS_CMD && fr.rw && fr.addr[0] && fr.addr[6:1] != 6'h00
			&& low_ok_q && low_addr_q == {fr.addr[6:1], 1'b0}) begin
			mem_q[wr_idx] <= {fr.data, low_hold_q}; // [RULE_07] [RULE_13]
		end else if (samp_ev) begin
			mem_q[1] <= sample_q; // [RULE_15]
		end
	end

	// read reply is latched for the next frame only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_word_q <= 16'h0000;
			tx_en_q   <= 1'b0;
		end else if (st_q == PS_CMD) begin
			tx_en_q <= !fr.rw; // [RULE_10] [RULE_19] [RULE_20]
			if (!fr.rw && fr.addr[6:1] == 6'h00) begin
				tx_word_q <= {8'h00, page_q}; // [RULE_06]
			end else if (!fr.rw) begin
				tx_word_q <= rd_word;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample timing: internal divider, or external sync edges
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_ff_q   <= 2'b00;
			sync_last_q <= 1'b0;
		end else begin
			sync_ff_q   <= {sync_ff_q[0], config_io_first_i};
			sync_last_q <= sync_ff_q[1]; // [RULE_18]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			samp_cnt_q <= 13'h0000;
		end else if (samp_cnt_q == SAMPLE_CYC_W - 13'h0001) begin
			samp_cnt_q <= 13'h0000;
		end else begin
			samp_cnt_q <= samp_cnt_q + 13'h0001;
		end
	end

	assign samp_ev = ext_sync_en ? (sync_ff_q[1] && !sync_last_q)
		: (samp_cnt_q == SAMPLE_CYC_W - 13'h0001);

	// no sensor here: a counter stands in for processed data
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_q <= DATA_RESET;
			drdy_q   <= 1'b0;
		end else begin
			drdy_q <= samp_ev; // [RULE_16]
			if (samp_ev) begin
				sample_q <= sample_q + SAMPLE_STEP;
			end
		end
	end

	assign config_io_second_o  = drdy_q;
	assign config_io_second_oe = 1'b1;

	////////////////////////////////////////////////////////////////////////
	page_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		page_q <= PAGE_MAX) else $error("page out of range"); // [RULE_09]

	page_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == PS_CMD && frame_w == 16'h8003) |=> page_q == PAGE_CONTROL)
		else $error("page select failed"); // [RULE_14]

	read_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == PS_CMD |=> tx_en_q == !$past(fr.rw))
		else $error("reply enable wrong"); // [RULE_20]

	page_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == PS_CMD && !fr.rw && fr.addr[6:1] == 6'h00)
		|=> tx_word_q == {8'h00, $past(page_q)})
		else $error("page readback wrong"); // [RULE_08]

	drdy_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		samp_ev |=> config_io_second_o ##1 !config_io_second_o || samp_ev)
		else $error("data ready pulse wrong"); // [RULE_16]

	seq_order_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == PS_CMD |=> st_q == PS_DONE ##1 st_q == PS_IDLE)
		else $error("sequencer order wrong"); // [RULE_10]

	samp_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!ext_sync_en && samp_ev) |=> !samp_ev [*8])
		else $error("sample rate wrong"); // [RULE_15]

	low_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == PS_CMD && fr.rw && !fr.addr[0])
		|=> low_ok_q && low_hold_q == $past(fr.data))
		else $error("low byte not held"); // [RULE_12]

	page_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q != PS_CMD |=> page_q == $past(page_q))
		else $error("page changed without command"); // [RULE_12]

	page_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == PS_CMD && fr.rw && fr.addr == ADDR_PAGE_SEL
		&& fr.data > PAGE_MAX) |=> page_q == $past(page_q))
		else $error("bad page code taken"); // [RULE_09]

	miso_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		cs_n |-> !miso_oe)
		else $error("output driven while deselected"); // [RULE_21]

	cmd_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == PS_IDLE && frame_ev) |=> st_q == PS_CMD)
		else $error("frame not decoded"); // [RULE_10]

	sample_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		samp_ev |=> sample_q == $past(sample_q) + SAMPLE_STEP)
		else $error("sample not advanced"); // [RULE_15]
endmodule
`default_nettype wire

// >>> bench/psrp_master.sv
// partner model: serial master, mode 3, one frame per xfer call
// assumes the bench spaces frames; sclk stands high between frames
`default_nettype none
module psrp_master (
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso_o,
	input  wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// fewer than 16 bits gives an aborted frame
	task automatic xfer(input logic [15:0] tx, input int n,
		output logic [15:0] rx, output logic oe);
		rx = 16'h0000;
		oe = 1'b0;
		cs_n = 1'b0;
		#40;
		for (int i = 15; i > 15 - n; i--) begin
			sclk = 1'b0;
			mosi = tx[i];
			#24;
			rx[i] = miso_o;
			oe = miso_oe;
			sclk = 1'b1;
			#24;
		end
		#16;
		cs_n = 1'b1;
		mosi = ~mosi; // released line must not hold a stale bit
	endtask
endmodule
`default_nettype wire

// >>> bench/test_paged_spi_register_port.sv
// bench top: register port driven through the serial master model
// assumes 10 MHz core clock and the master's xfer task
`default_nettype none
module test_paged_spi_register_port
	import psrp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, sclk, cs_n, mosi, miso_o, miso_oe;
	logic        ext_sync_en, config_io_first_i;
	logic        config_io_second_o, config_io_second_oe, oe;
	logic [15:0] rx, v0, v1;
	int          mismatches, num_checks, pulses, c, p0;
	psrp_top psrp_top_inst (.clk(clk), .rst_n(rst_n), .sclk(sclk),
		.cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
		.ext_sync_en(ext_sync_en), .config_io_first_i(config_io_first_i),
		.config_io_second_o(config_io_second_o),
		.config_io_second_oe(config_io_second_oe));
	psrp_master psrp_master_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso_o(miso_o), .miso_oe(miso_oe));
	initial clk = 1'b0;
	always #50 clk = ~clk;
	always @(posedge clk) if (config_io_second_o === 1'b1) pulses++;
	////////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic frame(logic [15:0] tx, int n = 16);
		psrp_master_inst.xfer(tx, n, rx, oe);
		tick(25);
		chk("release", 16'h0000, {15'h0000, miso_oe});
	endtask
	task automatic rd(logic [6:0] a, output logic [15:0] v);
		frame({1'b0, a, 8'h00});
		frame(16'h0000);
		chk("reply_oe", 16'h0001, {15'h0000, oe});
		v = rx;
	endtask
	task automatic wait_rdy();
		c = 0;
		while (config_io_second_o !== 1'b1 && c < 5000) begin
			tick(1);
			c++;
		end
	endtask
	task automatic finish_test();
		if (mismatches == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		frame(16'h0000);
		chk("first_oe", 16'h0000, {15'h0000, oe});
		rd(7'h00, v0);
		chk("page_rst", {8'h00, PAGE_RESET}, rx);
	endtask
	task automatic t_pages();
		for (int p = 0; p <= 13; p++) begin
			frame({8'h80, 8'(p)});
			rd(7'(p % 2), v0);
			chk("page", {8'h00, (p > 12) ? PAGE_MAX : 8'(p)}, v0);
		end
		frame(16'h8003);
		rd(7'h00, v0);
		chk("ctrl_page", {8'h00, PAGE_CONTROL}, v0);
	endtask
	task automatic t_bytes();
		frame(16'h8002);
		frame(16'h8455);
		frame(16'h85AA);
		frame(16'h0400);
		chk("wr_oe", 16'h0000, {15'h0000, oe});
		frame(16'h0000);
		chk("word", 16'hAA55, rx);
		frame(16'h8412);
		rd(7'h05, v0);
		chk("low_only", 16'hAA55, v0);
		frame(16'h8007, 8);
		frame(16'h8001);
		rd(7'h00, v0);
		chk("abort", 16'h0001, v0);
	endtask
	task automatic t_ready();
		frame(16'h8000);
		chk("rdy_oe", 16'h0001, {15'h0000, config_io_second_oe});
		wait_rdy();
		tick(1);
		chk("rdy_width", 16'h0000, {15'h0000, config_io_second_o});
		wait_rdy();
		chk("interval", 16'(SAMPLE_CYC), 16'(c + 1));
		tick(1);
		rd(7'h02, v0);
		wait_rdy();
		tick(1);
		rd(7'h02, v1);
		chk("sample", v0 + SAMPLE_STEP, v1);
	endtask
	task automatic t_sync();
		ext_sync_en = 1'b1;
		tick(10);
		p0 = pulses;
		tick(4500);
		chk("no_sync", 16'h0000, 16'(pulses - p0));
		config_io_first_i = 1'b1;
		tick(SYNC_PULSE_CYC);
		config_io_first_i = 1'b0;
		tick(10);
		chk("sync", 16'h0001, 16'(pulses - p0));
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b1;
		ext_sync_en = 1'b0;
		config_io_first_i = 1'b0;
		#1;
		rst_n = 1'b0;
		tick(16);
		rst_n = 1'b1;
		tick(4);
		t_reset();
		t_pages();
		t_bytes();
		t_ready();
		t_sync();
		finish_test();
	end
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		finish_test();
	end
endmodule
`default_nettype wire
